//--- verilog/btc_pkg.sv
/*
 Constants and carrier types of the termination controller.
 Imported whole by the design module.
*/
`default_nettype none
package btc_pkg;
    // --------------------
    // Sizes and timing
    // --------------------
    localparam int AW = 64;
    localparam int DW = 32;
    localparam int CW = 4;
    localparam int NW = 8;
    localparam int RETRY_W = 24;
    localparam int RETRY_LIMIT_DEF = 2 ** 24;
    localparam int MABORT_CLKS = 5;
    localparam int MTO_CLKS_DEF = 32768;
    localparam int PW_MIN_DWORDS = 8;
    localparam int PW_ADDR_DWORDS = 1;
    localparam int FIFO_DEPTH = 8;
    localparam logic [DW-1:0] MABORT_DATA = 32'hFFFF_FFFF;
    localparam logic [NW-1:0] ONE_WORD = 8'h01;
    localparam logic [NW-1:0] PW_NEED = 8'(PW_MIN_DWORDS + PW_ADDR_DWORDS);

    // --------------------
    // Enumerations
    // --------------------
    typedef enum logic [1:0] {K_DRD, K_DWR, K_PWR} btc_kind_t;
    typedef enum logic [2:0] {
        RSP_NONE, RSP_DATA, RSP_RETRY, RSP_DISC, RSP_TABORT
    } btc_rsp_t;
    typedef enum logic [1:0] {TT_NORMAL, TT_RETRY, TT_DISC, TT_ABORT} btc_term_t;

    // --------------------
    // Carriers
    // --------------------
    typedef struct packed {
        logic valid;
        btc_kind_t kind;
        logic from_pri;
        logic [AW-1:0] addr;
        logic [CW-1:0] cmd;
        logic prefetch;
        logic locked;
        logic [NW-1:0] dwords;
        logic [DW-1:0] wdata;
    } btc_req_t;

    typedef struct packed {
        logic valid;
        btc_term_t term;
        logic [NW-1:0] words;
    } btc_tgt_t;

    typedef struct packed {
        logic rcv_tabort;
        logic sig_tabort;
        logic rcv_mabort;
    } btc_sta_t;

    typedef struct packed {
        logic valid;
        logic from_pri;
        logic is_io;
        logic is_mem;
        logic in_io;
        logic in_mem;
        logic in_pf;
        logic [AW-1:0] addr;
    } btc_fwd_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [CW-1:0] cmd;
        logic is_read;
        logic to_sec;
        logic [DW-1:0] wdata;
    } btc_cmd_t;
endpackage : btc_pkg
`default_nettype wire

//--- verilog/btc_top.sv
/*
 Delayed-slot termination, posted-write retry,
 read-data FIFO and forwarding claim.
 Assumes a bus sequencer on ref_clk feeding range hits;
 all inputs are synchronous to ref_clk.
*/
// What this block does
// - Normal read end: disconnect per prefetch, length
// - Target retry restarts the same read
// - Target disconnect, more wanted: pass disconnect back
// - Target abort relayed, both abort flags set
// - Repeat until data, either abort, limit
// - Limit reached raises system error if enabled
// - Limit reached: drop request, abort next attempt
// - Delayed write retried while pending; no ordering block
// - Delayed read retried while pending or blocked
// - Read retried while prefetched data flushes
// - Non-locked access retried during lock
// - Posted write retried without room for nine
// - Unrepeated delayed access dropped after timeout
// - Disconnect at boundary, full, data exhausted
// - Signaled abort flag set on every target-abort answer
// - Three ranges forward down, rest up
// - Address passed unchanged, no gaps
// - No select within five clocks: master abort
// - I/O down needs enable, up needs master
`timescale 1ns/1ps
`default_nettype none

module btc_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output var logic in_ready,
    output var logic out_valid,
    output var logic [W-1:0] out_data,
    input wire logic out_ready,
    output var logic [$clog2(D+1)-1:0] count
);
    localparam int AWF = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [AWF-1:0] wp_ff, rp_ff;
    logic [$clog2(D+1)-1:0] cnt_ff, nxt_cnt;
    logic full_ff, empty_ff;
    logic push, pop;

    assign push = in_valid && !full_ff && !flush;
    assign pop = out_ready && !empty_ff && !flush;
    assign nxt_cnt = flush ? '0 : cnt_ff + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    assign in_ready = !full_ff;
    assign out_valid = !empty_ff;
    assign out_data = mem_ff[rp_ff];
    assign count = cnt_ff;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) wp_ff <= (int'(wp_ff) == D - 1) ? '0 : wp_ff + 1'b1;
            if (pop) rp_ff <= (int'(rp_ff) == D - 1) ? '0 : rp_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            full_ff <= (int'(nxt_cnt) == D);
            empty_ff <= (nxt_cnt == '0);
        end
    end
endmodule : btc_fifo

module btc_top
    import btc_pkg::*;
#(
    parameter int RETRY_LIMIT = RETRY_LIMIT_DEF,
    parameter int MTO_CLKS = MTO_CLKS_DEF,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire btc_req_t ini_req,
    output var btc_rsp_t ini_rsp_ff,
    output var logic [DW-1:0] ini_rdata_ff,
    output var logic tgt_issue_ff,
    output var btc_cmd_t tgt_cmd_ff,
    input wire logic tgt_frame,
    input wire logic tgt_devsel,
    output var logic tgt_mabort_ff,
    input wire btc_tgt_t tgt_resp,
    input wire logic tgt_rvalid,
    input wire logic [DW-1:0] tgt_rdata,
    output var logic tgt_rready,
    input wire logic io_en,
    input wire logic mem_en,
    input wire logic master_en,
    input wire logic serr_en,
    input wire logic serr_dis_retry,
    input wire logic mabort_mode,
    input wire logic lock_active,
    input wire logic flush_busy,
    input wire logic rd_head_ok,
    input wire logic pw_ahead,
    input wire logic at_boundary,
    input wire logic wr_full,
    input wire logic [NW-1:0] pw_free_dw,
    input wire btc_sta_t sta_clr_pri,
    input wire btc_sta_t sta_clr_sec,
    output var btc_sta_t sta_pri_ff,
    output var btc_sta_t sta_sec_ff,
    output var logic serr_n_ff,
    input wire btc_fwd_t fwd_in,
    output var logic fwd_down_ff,
    output var logic fwd_up_ff,
    output var logic [AW-1:0] fwd_addr_ff
);
    // --------------------
    // Slot state
    // --------------------
    typedef enum logic [2:0] {S_IDLE, S_ENTER, S_ISSUE, S_WAIT, S_DONE, S_TABORT} btc_st_t;
    localparam int MTW = $clog2(MTO_CLKS + 1);
    localparam int MAW = $clog2(MABORT_CLKS + 1);
    localparam logic [RETRY_W-1:0] LAST_TRY = RETRY_W'(RETRY_LIMIT - 1);

    btc_st_t st_ff, nxt_st;
    btc_req_t slot_ff;
    logic [RETRY_W-1:0] cnt_ff;
    logic [MTW-1:0] mto_ff;
    logic [MAW-1:0] mab_cnt_ff;
    logic mab_run_ff, mab_got_ff, abt_got_ff;

    // --------------------
    // FIFO for delayed read data
    // --------------------
    logic fifo_flush, fifo_pop, fifo_valid;
    logic [DW-1:0] fifo_data;
    logic [$clog2(DEPTH+1)-1:0] fifo_cnt;

    btc_fifo #(.W(DW), .D(DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .flush(fifo_flush),
        .in_valid(tgt_rvalid),
        .in_data(tgt_rdata),
        .in_ready(tgt_rready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop),
        .count(fifo_cnt)
    );

    // --------------------
    // Initiator side decode
    // --------------------
    logic is_delayed, is_read, lock_block, hit, busy, pending;
    logic rd_blocked, last_word, rd_disc, wr_disc, pw_room;
    logic compl, compl_free, tmo_hit;
    btc_rsp_t done_rsp, nxt_rsp;

    assign is_delayed = ini_req.valid && ini_req.kind != K_PWR;
    assign is_read = ini_req.kind == K_DRD;
    assign lock_block = lock_active && !ini_req.locked;
    assign busy = st_ff != S_IDLE;
    assign hit = busy && slot_ff.kind == ini_req.kind && slot_ff.addr == ini_req.addr
        && slot_ff.cmd == ini_req.cmd && slot_ff.from_pri == ini_req.from_pri;
    assign pending = st_ff == S_ENTER || st_ff == S_ISSUE || st_ff == S_WAIT;
    assign rd_blocked = is_read && (!rd_head_ok || pw_ahead);
    assign last_word = fifo_cnt <= 1;
    // Prefetchable reads end when data runs dry
    assign rd_disc = !slot_ff.prefetch
        || (ini_req.dwords > ONE_WORD && last_word) || at_boundary;
    assign wr_disc = ini_req.dwords > ONE_WORD || at_boundary || wr_full;
    assign pw_room = pw_free_dw >= PW_NEED;

    assign done_rsp = abt_got_ff ? RSP_TABORT
        : mab_got_ff ? (mabort_mode ? RSP_TABORT : RSP_DATA)
        : is_read ? (rd_disc ? RSP_DISC : RSP_DATA)
        : (wr_disc ? RSP_DISC : RSP_DATA);

    assign compl = is_delayed && !lock_block && hit && st_ff == S_DONE && !rd_blocked;
    assign compl_free = compl && (!is_read || mab_got_ff || abt_got_ff
        || done_rsp == RSP_DISC || last_word);
    assign fifo_pop = compl && is_read && !mab_got_ff && !abt_got_ff;
    assign tmo_hit = (st_ff == S_DONE || st_ff == S_TABORT) && int'(mto_ff) == MTO_CLKS;

    always_comb begin
        nxt_rsp = RSP_NONE;
        if (ini_req.valid) begin
            if (lock_block) begin
                nxt_rsp = RSP_RETRY;
            end else if (ini_req.kind == K_PWR) begin
                nxt_rsp = !pw_room ? RSP_RETRY : (wr_disc ? RSP_DISC : RSP_DATA);
            end else if (is_read && flush_busy) begin
                nxt_rsp = RSP_RETRY;
            end else if (!hit || pending) begin
                nxt_rsp = RSP_RETRY;
            end else if (st_ff == S_TABORT) begin
                nxt_rsp = RSP_TABORT;
            end else if (rd_blocked) begin
                nxt_rsp = RSP_RETRY;
            end else begin
                nxt_rsp = done_rsp;
            end
        end
    end

    // --------------------
    // Target side outcome
    // --------------------
    logic mab_fire, t_ok, t_retry, t_abort, exhausted;

    assign mab_fire = st_ff == S_WAIT && mab_run_ff && !tgt_devsel
        && int'(mab_cnt_ff) == MABORT_CLKS;
    // A disconnect with no data counts as a retry
    assign t_ok = tgt_resp.valid && tgt_resp.words != '0
        && (tgt_resp.term == TT_NORMAL || tgt_resp.term == TT_DISC);
    assign t_retry = tgt_resp.valid && !t_ok && tgt_resp.term != TT_ABORT;
    assign t_abort = tgt_resp.valid && tgt_resp.term == TT_ABORT;
    assign exhausted = st_ff == S_WAIT && t_retry && cnt_ff == LAST_TRY;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            S_IDLE: begin
                if (is_delayed && !lock_block && !(is_read && flush_busy)) nxt_st = S_ENTER;
            end
            S_ENTER: nxt_st = S_ISSUE;
            S_ISSUE: nxt_st = S_WAIT;
            S_WAIT: begin
                if (exhausted) nxt_st = S_TABORT;
                else if (t_retry) nxt_st = S_ISSUE;
                else if (t_ok || t_abort || mab_fire) nxt_st = S_DONE;
            end
            S_DONE: begin
                if (compl_free || tmo_hit) nxt_st = S_IDLE;
            end
            S_TABORT: begin
                if ((nxt_rsp == RSP_TABORT && hit) || tmo_hit) nxt_st = S_IDLE;
            end
            default: nxt_st = S_IDLE;
        endcase
    end

    assign fifo_flush = (st_ff == S_DONE && (compl_free || tmo_hit)) || st_ff == S_ENTER;

    always_ff @(posedge ref_clk) begin
        if (rst) st_ff <= S_IDLE;
        else st_ff <= nxt_st;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slot_ff <= '0;
        end else if (st_ff == S_IDLE && nxt_st == S_ENTER) begin
            slot_ff <= ini_req;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || st_ff == S_ENTER) cnt_ff <= '0;
        else if (st_ff == S_WAIT && t_retry && !exhausted) cnt_ff <= cnt_ff + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || nxt_st != st_ff || (ini_req.valid && hit)) mto_ff <= '0;
        else if ((st_ff == S_DONE || st_ff == S_TABORT) && !tmo_hit) mto_ff <= mto_ff + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || st_ff != S_WAIT || tgt_devsel) begin
            mab_run_ff <= 1'b0;
            mab_cnt_ff <= '0;
        end else if (tgt_frame) begin
            mab_run_ff <= 1'b1;
            mab_cnt_ff <= MAW'(1);
        end else if (mab_run_ff && !mab_fire) begin
            mab_cnt_ff <= mab_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || st_ff == S_ENTER) begin
            mab_got_ff <= 1'b0;
            abt_got_ff <= 1'b0;
        end else if (st_ff == S_WAIT) begin
            if (mab_fire) mab_got_ff <= 1'b1;
            if (t_abort) abt_got_ff <= 1'b1;
        end
    end

    // --------------------
    // Status flags; set wins over clear
    // --------------------
    btc_sta_t set_tgt, set_ini, set_pri, set_sec;
    logic sig_abort;

    assign sig_abort = nxt_rsp == RSP_TABORT && is_delayed;
    assign set_tgt = '{rcv_tabort: st_ff == S_WAIT && t_abort, sig_tabort: 1'b0,
        rcv_mabort: mab_fire};
    assign set_ini = '{rcv_tabort: 1'b0, sig_tabort: sig_abort, rcv_mabort: 1'b0};
    assign set_pri = slot_ff.from_pri ? set_ini : set_tgt;
    assign set_sec = slot_ff.from_pri ? set_tgt : set_ini;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sta_pri_ff <= '0;
            sta_sec_ff <= '0;
        end else begin
            sta_pri_ff <= (sta_pri_ff & ~sta_clr_pri) | set_pri;
            sta_sec_ff <= (sta_sec_ff & ~sta_clr_sec) | set_sec;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) serr_n_ff <= 1'b1;
        else serr_n_ff <= !(exhausted && serr_en && !serr_dis_retry);
    end

    // --------------------
    // Initiator and target outputs
    // --------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ini_rsp_ff <= RSP_NONE;
            ini_rdata_ff <= '0;
        end else begin
            ini_rsp_ff <= nxt_rsp;
            if (compl && mab_got_ff) ini_rdata_ff <= MABORT_DATA;
            else if (fifo_pop && fifo_valid) ini_rdata_ff <= fifo_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tgt_issue_ff <= 1'b0;
            tgt_cmd_ff <= '0;
            tgt_mabort_ff <= 1'b0;
        end else begin
            tgt_issue_ff <= st_ff == S_ISSUE;
            tgt_mabort_ff <= mab_fire;
            if (st_ff == S_ISSUE) begin
                tgt_cmd_ff <= '{addr: slot_ff.addr, cmd: slot_ff.cmd,
                    is_read: slot_ff.kind == K_DRD, to_sec: slot_ff.from_pri,
                    wdata: slot_ff.wdata};
            end
        end
    end

    // --------------------
    // Forwarding claim
    // --------------------
    logic in_mem_any, claim_down, claim_up;

    assign in_mem_any = fwd_in.in_mem || fwd_in.in_pf;
    assign claim_down = fwd_in.valid && fwd_in.from_pri
        && ((fwd_in.is_io && fwd_in.in_io && io_en)
        || (fwd_in.is_mem && in_mem_any && mem_en));
    assign claim_up = fwd_in.valid && !fwd_in.from_pri && master_en
        && ((fwd_in.is_io && !fwd_in.in_io)
        || (fwd_in.is_mem && !in_mem_any));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fwd_down_ff <= 1'b0;
            fwd_up_ff <= 1'b0;
            fwd_addr_ff <= '0;
        end else begin
            fwd_down_ff <= claim_down;
            fwd_up_ff <= claim_up;
            fwd_addr_ff <= fwd_in.addr;
        end
    end
endmodule : btc_top
`default_nettype wire

//--- bench/btc_sva.sv
/*
 Concurrent checks on the ports of btc_top.
 Assumes binding into btc_top, one clock ref_clk and sync reset rst.
*/
`timescale 1ns/1ps
`default_nettype none
module btc_chk
    import btc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire btc_req_t ini_req,
    input wire btc_rsp_t ini_rsp_ff,
    input wire logic lock_active,
    input wire logic flush_busy,
    input wire logic [NW-1:0] pw_free_dw,
    input wire logic tgt_frame,
    input wire logic tgt_devsel,
    input wire logic tgt_mabort_ff,
    input wire logic tgt_rready,
    input wire logic serr_en,
    input wire logic serr_dis_retry,
    input wire logic serr_n_ff,
    input wire btc_sta_t sta_pri_ff,
    input wire btc_sta_t sta_sec_ff,
    input wire logic io_en,
    input wire logic mem_en,
    input wire logic master_en,
    input wire btc_fwd_t fwd_in,
    input wire logic fwd_down_ff,
    input wire logic fwd_up_ff,
    input wire logic [AW-1:0] fwd_addr_ff
);
    // ----------------------------------------
    // Expected forwarding claims
    // ----------------------------------------
    wire logic hit = fwd_in.in_mem | fwd_in.in_pf;
    wire logic dn = fwd_in.from_pri & ((fwd_in.is_io & fwd_in.in_io & io_en)
        | (fwd_in.is_mem & hit & mem_en));
    wire logic up = !fwd_in.from_pri & master_en & ((fwd_in.is_io & !fwd_in.in_io)
        | (fwd_in.is_mem & !hit));
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    chk_rsp_idle: assert property (!$past(ini_req.valid) |-> ini_rsp_ff == RSP_NONE)
        else $error("answer without attempt");
    chk_lock_retry: assert property (
        ini_req.valid && lock_active && !ini_req.locked |=> ini_rsp_ff == RSP_RETRY)
        else $error("unlocked access not retried");
    chk_pw_room: assert property (
        ini_req.valid && ini_req.kind == K_PWR && pw_free_dw < PW_NEED
        |=> ini_rsp_ff == RSP_RETRY) else $error("posted write without room");
    chk_flush_retry: assert property (
        ini_req.valid && ini_req.kind == K_DRD && flush_busy |=> ini_rsp_ff == RSP_RETRY)
        else $error("read during flush not retried");
    chk_fwd_addr: assert property (
        fwd_in.valid |=> fwd_addr_ff == $past(fwd_in.addr)) else $error("address changed");
    chk_fwd_down: assert property (
        fwd_in.valid |=> fwd_down_ff == $past(dn)) else $error("downstream claim wrong");
    chk_fwd_up: assert property (
        fwd_in.valid |=> fwd_up_ff == $past(up)) else $error("upstream claim wrong");
    chk_mabort_time: assert property (
        tgt_frame && !tgt_devsel ##1 !tgt_devsel [*5] |=> tgt_mabort_ff)
        else $error("master abort late");
    chk_serr_gate: assert property (
        !serr_n_ff |-> $past(serr_en) && !$past(serr_dis_retry))
        else $error("system error not enabled");
    chk_sig_abort: assert property (
        ini_rsp_ff == RSP_TABORT |-> ##[0:1] (sta_pri_ff.sig_tabort || sta_sec_ff.sig_tabort))
        else $error("signaled abort flag missing");
    cover property (ini_rsp_ff == RSP_TABORT);
    cover property (tgt_mabort_ff);
    cover property (!serr_n_ff);
    cover property (!tgt_rready);
endmodule : btc_chk
`default_nettype wire

//--- bench/btc_tgt_model.sv
/*
 Target-bus partner: frame, select, read data push and termination.
 Assumes the bench sets term, word count, select and data base.
*/
`timescale 1ns/1ps
`default_nettype none
module btc_tgt_model
    import btc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tgt_issue_ff,
    input wire btc_cmd_t tgt_cmd_ff,
    input wire logic tgt_rready,
    input wire btc_term_t pt,
    input wire logic [NW-1:0] pn,
    input wire logic ps,
    input wire logic [DW-1:0] pd,
    output var logic tgt_frame,
    output var logic tgt_devsel,
    output var btc_tgt_t tgt_resp,
    output var logic tgt_rvalid,
    output var logic [DW-1:0] tgt_rdata
);
    initial {tgt_frame, tgt_devsel, tgt_resp, tgt_rvalid, tgt_rdata} = '0;
    // ----------------------------------------
    // One transaction per issue, with a varying delay
    // ----------------------------------------
    always begin
        @(negedge ref_clk);
        if (tgt_issue_ff && !rst) begin
            repeat (pd[1:0]) @(negedge ref_clk);
            tgt_frame = 1;
            tgt_devsel = ps;
            @(negedge ref_clk);
            tgt_frame = 0;
            if (ps) begin
                if (tgt_cmd_ff.is_read && pt != TT_RETRY && pt != TT_ABORT)
                    for (int i = 0; i < pn; i++) begin
                        tgt_rvalid = 1;
                        tgt_rdata = pd + DW'(i);
                        do @(posedge ref_clk); while (!tgt_rready);
                        @(negedge ref_clk);
                    end
                tgt_rvalid = 0;
                tgt_rdata = ~tgt_rdata;
                tgt_resp = '{1'b1, pt, pn};
                @(negedge ref_clk);
                tgt_resp.valid = 0;
                tgt_devsel = 0;
            end
        end
    end
endmodule : btc_tgt_model
`default_nettype wire

//--- bench/bridge_termination_control_bench.sv
/*
 Self-checking bench of btc_top with the target partner.
 Assumes short retry limit and timeout parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module bridge_termination_control_bench;
    import btc_pkg::*;
    localparam int RL = 4;
    localparam int MT = 16;
    logic ref_clk = 0;
    logic rst = 1;
    btc_req_t ini_req;
    btc_rsp_t ini_rsp_ff, r;
    btc_cmd_t tgt_cmd_ff;
    btc_tgt_t tgt_resp;
    btc_term_t pt;
    btc_sta_t sta_clr_pri, sta_clr_sec, sta_pri_ff, sta_sec_ff;
    btc_fwd_t fwd_in;
    logic [DW-1:0] ini_rdata_ff, tgt_rdata, pd, d;
    logic [DW-1:0] q[$];
    logic [NW-1:0] pw_free_dw, pn;
    logic [AW-1:0] fwd_addr_ff;
    logic tgt_issue_ff, tgt_frame, tgt_devsel, tgt_mabort_ff, tgt_rvalid, tgt_rready;
    logic io_en, mem_en, master_en, serr_en, serr_dis_retry, mabort_mode, lock_active;
    logic flush_busy, rd_head_ok, pw_ahead, at_boundary, wr_full, serr_n_ff;
    logic fwd_down_ff, fwd_up_ff, ps, saw_full, e_dn, e_up;
    int err_count = 0;
    int check_count = 0;
    int n_iss, n_serr;
    btc_top #(.RETRY_LIMIT(RL), .MTO_CLKS(MT)) btc_top_i (.*);
    btc_tgt_model btc_tgt_model_i (.*);
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (tgt_issue_ff) n_iss++;
        if (!serr_n_ff) n_serr++;
        if (!tgt_rready && !rst) saw_full = 1;
    end
    // ----------------------------------------
    // Compare, attempt and verdict tasks
    // ----------------------------------------
    task chk_r(input btc_rsp_t g, input btc_rsp_t e);
        chk_v(AW'(g), AW'(e));
    endtask : chk_r
    task chk_v(input logic [AW-1:0] g, input logic [AW-1:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_v
    task att;
        ini_req.valid = 1;
        @(negedge ref_clk);
        ini_req.valid = 0;
        r = ini_rsp_ff;
        d = ini_rdata_ff;
        @(negedge ref_clk);
    endtask : att
    task prep(input btc_term_t t, input int n, input logic s);
        pt = t;
        pn = NW'(n);
        ps = s;
        pd = $urandom;
        n_iss = 0;
        n_serr = 0;
        if (ini_req.kind == K_DRD && t != TT_RETRY && t != TT_ABORT && s)
            for (int i = 0; i < n; i++) q.push_back(pd + DW'(i));
    endtask : prep
    task wt;
        for (int i = 0; i < 200 && r === RSP_RETRY; i++) att();
    endtask : wt
    task go(input btc_term_t t, input int n, input logic s);
        ini_req.addr = {$urandom, $urandom};
        prep(t, n, s);
        att();
        chk_r(r, RSP_RETRY);
        wt();
    endtask : go
    task clr;
        sta_clr_pri = '1;
        sta_clr_sec = '1;
        @(negedge ref_clk);
        sta_clr_pri = '0;
        sta_clr_sec = '0;
        @(negedge ref_clk);
        chk_v({sta_pri_ff, sta_sec_ff}, 0);
    endtask : clr
    task end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    initial begin
        #(20000 * 4);
        err_count++;
        end_of_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(62));
        ini_req = '0;
        ini_req.from_pri = 1;
        ini_req.cmd = 4'h6;
        {io_en, mem_en, master_en, serr_en, serr_dis_retry, mabort_mode} = 6'b11_1100;
        {lock_active, flush_busy, pw_ahead, at_boundary, wr_full} = '0;
        rd_head_ok = 1;
        pw_free_dw = 8'hFF;
        sta_clr_pri = '0;
        sta_clr_sec = '0;
        fwd_in = '0;
        prep(TT_NORMAL, 0, 1);
        saw_full = 0;
        repeat (5) @(negedge ref_clk);
        rst = 0;
        chk_r(ini_rsp_ff, RSP_NONE);
        chk_v({serr_n_ff, tgt_rready, sta_pri_ff, sta_sec_ff}, 8'hC0);
        ini_req.prefetch = 1;
        ini_req.dwords = 8'h08;
        go(TT_NORMAL, 8, 1);
        chk_v(tgt_cmd_ff.addr, ini_req.addr);
        chk_v(saw_full, 1);
        chk_v(n_iss, 1);
        for (int i = 0; i < 8; i++) begin
            if (i == 3) begin
                pw_ahead = 1;
                att();
                chk_r(r, RSP_RETRY);
                pw_ahead = 0;
            end
            if (i) att();
            chk_r(r, i == 7 ? RSP_DISC : RSP_DATA);
            chk_v(d, q.pop_front());
        end
        for (int j = 0; j < 2; j++) begin
            ini_req.prefetch = j;
            ini_req.dwords = 8'h04;
            go(j ? TT_DISC : TT_NORMAL, 2, 1);
            chk_r(r, j ? RSP_DATA : RSP_DISC);
            chk_v(d, q.pop_front());
            if (j) att();
            if (j) chk_r(r, RSP_DISC);
            if (j) chk_v(d, q.pop_front());
            q.delete();
        end
        for (int j = 0; j < 2; j++) begin
            serr_dis_retry = j;
            go(TT_RETRY, 0, 1);
            chk_r(r, RSP_TABORT);
            chk_v(n_iss, RL);
            chk_v(n_serr, j ? 0 : 1);
            chk_v(sta_pri_ff.sig_tabort, 1);
            clr();
        end
        for (int j = 0; j < 2; j++) begin
            ini_req.from_pri = j;
            go(TT_ABORT, 0, 1);
            chk_r(r, RSP_TABORT);
            chk_v(j ? sta_sec_ff.rcv_tabort : sta_pri_ff.rcv_tabort, 1);
            chk_v(j ? sta_pri_ff.sig_tabort : sta_sec_ff.sig_tabort, 1);
            clr();
        end
        for (int j = 0; j < 2; j++) begin
            mabort_mode = j;
            go(TT_NORMAL, 0, 0);
            chk_r(r, j ? RSP_TABORT : RSP_DATA);
            chk_v(j ? MABORT_DATA : d, MABORT_DATA);
            chk_v(sta_sec_ff.rcv_mabort, 1);
            clr();
        end
        ini_req.dwords = 8'h01;
        prep(TT_NORMAL, 1, 1);
        att();
        repeat (MT + 40) @(negedge ref_clk);
        q.delete();
        prep(TT_NORMAL, 1, 1);
        att();
        chk_r(r, RSP_RETRY);
        wt();
        chk_r(r, RSP_DATA);
        chk_v(d, q.pop_front());
        ini_req.kind = K_DWR;
        ini_req.dwords = 8'h02;
        ini_req.wdata = $urandom;
        go(TT_NORMAL, 1, 1);
        chk_r(r, RSP_DISC);
        chk_v(tgt_cmd_ff.wdata, ini_req.wdata);
        ini_req.kind = K_DRD;
        lock_active = 1;
        att();
        chk_r(r, RSP_RETRY);
        lock_active = 0;
        flush_busy = 1;
        att();
        chk_r(r, RSP_RETRY);
        flush_busy = 0;
        ini_req.kind = K_PWR;
        for (int i = 0; i < 5; i++) begin
            pw_free_dw = i ? PW_NEED : PW_NEED - 8'h01;
            ini_req.dwords = i == 2 ? 8'h02 : ONE_WORD;
            at_boundary = i == 3;
            wr_full = i == 4;
            att();
            chk_r(r, i == 0 ? RSP_RETRY : i == 1 ? RSP_DATA : RSP_DISC);
        end
        for (int i = 0; i < 30; i++) begin
            fwd_in = {1'b1, 6'($urandom), $urandom, $urandom};
            {io_en, mem_en, master_en} = 3'($urandom);
            e_dn = fwd_in.from_pri & ((fwd_in.is_io & fwd_in.in_io & io_en)
                | (fwd_in.is_mem & (fwd_in.in_mem | fwd_in.in_pf) & mem_en));
            e_up = !fwd_in.from_pri & master_en & ((fwd_in.is_io & !fwd_in.in_io)
                | (fwd_in.is_mem & !(fwd_in.in_mem | fwd_in.in_pf)));
            @(negedge ref_clk);
            chk_v(fwd_down_ff, e_dn);
            chk_v(fwd_up_ff, e_up);
            chk_v(fwd_addr_ff, fwd_in.addr);
        end
        end_of_test();
    end
endmodule : bridge_termination_control_bench
bind btc_top btc_chk btc_chk_i (.*);
`default_nettype wire
